//--- rtl/iwd_dev_end.sv
// Module: wake-up detection, pending, enable and priority dispatch
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iwd_dev_end #(
    parameter int                NSRC     = iwd_pkg::NSRC,
    parameter logic [NSRC-1:0]   WAKE_SRC = iwd_pkg::WAKE_SRC_DEF,
    parameter logic [NSRC-1:0]   PIN_SRC  = iwd_pkg::PIN_SRC_DEF
) (
    input  wire logic                clk_in,    // System clock
    input  wire logic                rst_b_in,  // Async reset, active low
    iwd_link_if.dev                  link,      // Processor side
    input  wire logic [NSRC-1:0]     src_in,    // Sources; pins are async
    input  wire logic                stop_in,   // STOP mode active
    output logic [NSRC-1:0]          wake_out   // Held wake requests
);
    import iwd_pkg::*;

    if (NSRC != 32) begin : g_bad_nsrc
        $error("iwd_dev_end: register map serves exactly 32 sources");
    end

    // ==========================================================
    // State
    logic [NSRC-1:0]   en_r;          // Enables
    logic [NSRC-1:0]   pend_r;        // Pending
    logic [NSRC-1:0]   act_r;         // Active (in handler)
    logic [NSRC-1:0]   fsel_r;        // Pin function select
    logic [NSRC-1:0]   ie_r;          // Pin input enable
    logic [2*NSRC-1:0] prio_r;        // Priority fields
    logic [4*NSRC-1:0] wcfg_r;        // Wake mode control nibbles
    logic [NSRC-1:0]   meta_r;        // Pin sync stage 1
    logic [NSRC-1:0]   sync_r;        // Pin sync stage 2
    logic [DATA_W-1:0] rdata_r;       // Read data
    logic              valid_r;       // Offer to processor
    logic [ID_W-1:0]   id_r;          // Offered source
    logic [NSRC-1:0]   line_w;        // Line into pending logic
    logic [NSRC-1:0]   wreq_w;        // Detector outputs
    logic [NSRC-1:0]   src_w;         // Source after pin gating
    logic              sel_valid;     // A winner exists
    logic [ID_W-1:0]   sel_id;        // Winner
    logic [2:0]        sel_prio;      // Winner level
    logic [2:0]        run_prio;      // Level being serviced

    // Write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a);
        hit = link.cfg_wr && (link.cfg_addr == a);
    endfunction

    wire [NSRC-1:0] set_en_w   = hit(A_SET_EN)   ? link.cfg_wdata : '0;
    wire [NSRC-1:0] clr_en_w   = hit(A_CLR_EN)   ? link.cfg_wdata : '0;
    wire [NSRC-1:0] set_pend_w = hit(A_SET_PEND) ? link.cfg_wdata : '0;
    wire [NSRC-1:0] clr_pend_w = hit(A_CLR_PEND) ? link.cfg_wdata : '0;
    wire [NSRC-1:0] ack_vec    = link.irq_ack  ? (NSRC'(1) << id_r) : '0;
    wire [NSRC-1:0] done_vec   = link.irq_done ?
                                 (NSRC'(1) << link.done_id) : '0;
    wire            wclr_wr    = hit(A_WCLR);
    wire [ID_W-1:0] wclr_id    = link.cfg_wdata[ID_W-1:0];
    wire            wcfg_wr    = link.cfg_wr &&
                                 (link.cfg_addr >= A_WCFG0) &&
                                 (link.cfg_addr <= A_WCFG3);
    wire [1:0]      wcfg_word  = 2'(link.cfg_addr - A_WCFG0);

    // ==========================================================
    // Per-source routing and wake detectors
    for (genvar i = 0; i < NSRC; i++) begin : g_src
        if (PIN_SRC[i]) begin : g_pin
            // Disabled input reads high; STOP needs function select
            assign src_w[i] = !ie_r[i] ? 1'b1 :
                              (!stop_in || fsel_r[i]) ? sync_r[i] :
                              1'b0;
        end else begin : g_per
            assign src_w[i] = src_in[i];
        end
        if (WAKE_SRC[i]) begin : g_wake
            // Peripherals forced to edge modes
            wire [1:0] lvl = PIN_SRC[i] ? wcfg_r[4*i +: 2] :
                             {1'b1, wcfg_r[4*i]};
            iwd_wake_det u_det (
                .clk_in    (clk_in),
                .rst_b_in  (rst_b_in),
                .src_in    (src_w[i]),
                .enable_in (wcfg_r[4*i+WCFG_EN_BIT]),
                .level_in  (lvl),
                .clear_in  (wclr_wr && (wclr_id == ID_W'(i))),
                .req_out   (wreq_w[i])
            );
            assign line_w[i] = wreq_w[i];
        end else begin : g_direct
            assign wreq_w[i] = 1'b0;
            assign line_w[i] = src_w[i];   // Active high only
        end
    end

    // ==========================================================
    // Winner selection among enabled, pending, idle sources
    always_comb begin
        logic [NSRC-1:0] cand;
        cand      = pend_r & en_r & ~act_r;
        sel_valid = 1'b0;
        sel_id    = '0;
        sel_prio  = PRIO_IDLE;
        run_prio  = PRIO_IDLE;
        for (int k = 0; k < NSRC; k++) begin
            // Strict compare keeps lowest number on ties
            if (cand[k] && ({1'b0, prio_r[2*k +: 2]} < sel_prio)) begin
                sel_valid = 1'b1;
                sel_id    = ID_W'(k);
                sel_prio  = {1'b0, prio_r[2*k +: 2]};
            end
            if (act_r[k] && ({1'b0, prio_r[2*k +: 2]} < run_prio)) begin
                run_prio = {1'b0, prio_r[2*k +: 2]};
            end
        end
        // Only a more urgent level preempts the handler running
        sel_valid = sel_valid && (sel_prio < run_prio);
    end

    // ==========================================================
    // Pin synchroniser
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= src_in;
            sync_r <= meta_r;
        end
    end

    // Enable, pending, active; on pending, hardware set wins over clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_r   <= '0;
            pend_r <= '0;
            act_r  <= '0;
        end else begin
            en_r   <= (en_r | set_en_w) & ~clr_en_w;
            pend_r <= (pend_r & ~clr_pend_w & ~ack_vec)
                      | line_w | set_pend_w;
            act_r  <= (act_r | ack_vec) & ~done_vec;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prio_r <= '0;
            wcfg_r <= '0;
            fsel_r <= '0;
            ie_r   <= IE_RST;
        end else begin
            if (hit(A_PRIO0)) prio_r[31:0]  <= link.cfg_wdata;
            if (hit(A_PRIO1)) prio_r[63:32] <= link.cfg_wdata;
            if (wcfg_wr) wcfg_r[32*wcfg_word +: 32] <= link.cfg_wdata;
            if (hit(A_PIN_FSEL)) fsel_r <= link.cfg_wdata;
            if (hit(A_PIN_IE))   ie_r   <= link.cfg_wdata;
        end
    end

    // Offer and read data
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            valid_r <= 1'b0;
            id_r    <= '0;
            rdata_r <= '0;
        end else begin
            valid_r <= sel_valid && !link.irq_ack;
            id_r    <= sel_id;
            if (link.cfg_rd) begin
                case (link.cfg_addr)
                    A_SET_EN, A_CLR_EN:     rdata_r <= en_r;
                    A_SET_PEND, A_CLR_PEND: rdata_r <= pend_r;
                    A_PRIO0:    rdata_r <= prio_r[31:0];
                    A_PRIO1:    rdata_r <= prio_r[63:32];
                    8'h06, 8'h07, 8'h08, A_WCFG3:
                        rdata_r <= wcfg_r[32*wcfg_rd_word() +: 32];
                    A_WREQ:     rdata_r <= wreq_w;
                    A_ACTIVE:   rdata_r <= act_r;
                    A_PIN_FSEL: rdata_r <= fsel_r;
                    A_PIN_IE:   rdata_r <= ie_r;
                    default:    rdata_r <= '0;   // Unmapped reads 0
                endcase
            end else begin
                rdata_r <= '0;
            end
        end
    end

    // Read word select for wake mode control
    function automatic logic [1:0] wcfg_rd_word();
        wcfg_rd_word = 2'(link.cfg_addr - A_WCFG0);
    endfunction

    assign link.cfg_rdata = rdata_r;
    assign link.irq_valid = valid_r;
    assign link.irq_id    = id_r;
    assign wake_out       = wreq_w;
endmodule : iwd_dev_end
`default_nettype wire

//--- rtl/iwd_pkg.sv
// Package: shared constants for the wake-up detect and dispatch block
package iwd_pkg;
    // ==========================================================
    // Sizes
    localparam int NSRC    = 32;   // Interrupt sources
    localparam int ID_W    = 5;    // Source number width
    localparam int PRIO_W  = 2;    // Priority field width
    localparam int ADDR_W  = 8;    // Register word index width
    localparam int DATA_W  = 32;   // Register data width
    localparam int CODE_W  = 6;    // Exception code width
    // ==========================================================
    // Device register word indexes
    localparam logic [7:0] A_SET_EN   = 8'h00; // Set-enable / read enables
    localparam logic [7:0] A_CLR_EN   = 8'h01; // Clear-enable
    localparam logic [7:0] A_SET_PEND = 8'h02; // Set-pending / read pending
    localparam logic [7:0] A_CLR_PEND = 8'h03; // Clear-pending
    localparam logic [7:0] A_PRIO0    = 8'h04; // Priority, sources 0..15
    localparam logic [7:0] A_PRIO1    = 8'h05; // Priority, sources 16..31
    localparam logic [7:0] A_WCFG0    = 8'h06; // Wake mode ctrl, 8 per word
    localparam logic [7:0] A_WCFG3    = 8'h09; // Last wake mode ctrl word
    localparam logic [7:0] A_WCLR     = 8'h0A; // Wake request clear (source no.)
    localparam logic [7:0] A_WREQ     = 8'h0B; // Held wake requests
    localparam logic [7:0] A_ACTIVE   = 8'h0C; // Active sources
    localparam logic [7:0] A_PIN_FSEL = 8'h0D; // Pin function select
    localparam logic [7:0] A_PIN_IE   = 8'h0E; // Pin input enable
    // Processor-side register word indexes
    localparam logic [7:0] A_MASK     = 8'h40; // Global mask, bit 0
    localparam logic [7:0] A_STATUS   = 8'h41; // Current exception state
    localparam logic [7:0] A_EOI      = 8'h42; // End of handler, source no.
    // ==========================================================
    // Wake mode control nibble: [3] enable, [1:0] active level
    localparam int WCFG_EN_BIT = 3;
    localparam logic [1:0] LVL_LOW  = 2'h0;  // Low level
    localparam logic [1:0] LVL_HIGH = 2'h1;  // High level
    localparam logic [1:0] LVL_FALL = 2'h2;  // Falling edge
    localparam logic [1:0] LVL_RISE = 2'h3;  // Rising edge
    // ==========================================================
    // Source routing defaults
    localparam logic [31:0] WAKE_SRC_DEF = 32'h400001F0; // Via detector
    localparam logic [31:0] PIN_SRC_DEF  = 32'h000001E0; // Pin sources
    // ==========================================================
    // Reset values
    localparam logic        MASK_RST = 1'b0;   // Interrupts accepted
    localparam logic [31:0] IE_RST   = 32'h00000000; // Pin inputs off
    // ==========================================================
    // Exception codes and context save
    localparam logic [5:0] CODE_NONE  = 6'h00; // Thread mode
    localparam logic [5:0] CODE_NMI   = 6'h02; // Non-maskable
    localparam logic [5:0] CODE_FAULT = 6'h03; // Hard fault
    localparam logic [5:0] CODE_IRQ0  = 6'h10; // First source
    localparam int STACK_WORDS = 8;            // Words pushed on entry
    localparam logic [2:0] PRIO_IDLE = 3'h4;   // Below every level
endpackage : iwd_pkg

//--- rtl/iwd_link_if.sv
// Interface: link between the dispatch device and the processor end
`timescale 1ns/1ps
`default_nettype none
interface iwd_link_if;
    import iwd_pkg::*;
    logic              cfg_wr;     // Register write strobe
    logic              cfg_rd;     // Register read strobe
    logic [ADDR_W-1:0] cfg_addr;   // Register word index
    logic [DATA_W-1:0] cfg_wdata;  // Write data
    logic [DATA_W-1:0] cfg_rdata;  // Read data, cycle after strobe
    logic              irq_valid;  // Best request offered
    logic [ID_W-1:0]   irq_id;     // Its source number
    logic              irq_ack;    // Processor takes it
    logic              irq_done;   // Handler finished
    logic [ID_W-1:0]   done_id;    // Source whose handler ended
    modport dev (input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, irq_ack,
                 irq_done, done_id,
                 output cfg_rdata, irq_valid, irq_id);
    modport cpu (output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, irq_ack,
                 irq_done, done_id,
                 input cfg_rdata, irq_valid, irq_id);
endinterface : iwd_link_if
`default_nettype wire

//--- rtl/iwd_wake_det.sv
// Module: one source's wake-up request detector
`timescale 1ns/1ps
`default_nettype none
module iwd_wake_det (
    input  wire logic       clk_in,     // System clock
    input  wire logic       rst_b_in,   // Async reset, active low
    input  wire logic       src_in,     // Source level, same clock
    input  wire logic       enable_in,  // Detector enable
    input  wire logic [1:0] level_in,   // Active level selection
    input  wire logic       clear_in,   // Clear held request
    output logic            req_out     // Request to processor, high
);
    import iwd_pkg::*;
    logic src_prev_r;   // Source last cycle
    logic req_r;        // Held request
    logic req_nxt;      // Next request
    wire  is_edge  = level_in[1];                     // Edge modes
    wire  rise_w   = src_in & ~src_prev_r;            // Rising edge
    wire  fall_w   = ~src_in & src_prev_r;            // Falling edge
    wire  edge_hit = (level_in == LVL_RISE) ? rise_w : fall_w;
    wire  lvl_hit  = (level_in == LVL_HIGH) ? src_in : ~src_in;

    // ==========================================================
    // Request next value
    always_comb begin
        if (!enable_in) begin
            req_nxt = 1'b0;                   // Disabled source
        end else if (is_edge) begin
            // Edge latched; new edge wins over clear
            req_nxt = edge_hit | (req_r & ~clear_in);
        end else begin
            req_nxt = lvl_hit;                // Follows level
        end
    end

    // Registers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            src_prev_r <= 1'b0;
            req_r      <= 1'b0;
        end else begin
            src_prev_r <= src_in;
            req_r      <= req_nxt;
        end
    end

    assign req_out = req_r;                   // Held high level
endmodule : iwd_wake_det
`default_nettype wire

//--- rtl/iwd_cpu_end.sv
// Module: processor end: mask, acceptance, context save, software port
`timescale 1ns/1ps
`default_nettype none
module iwd_cpu_end (
    input  wire logic                 clk_in,     // System clock
    input  wire logic                 rst_b_in,   // Async reset, low
    iwd_link_if.cpu                   link,       // Device side
    input  wire logic [7:0]           addr_in,    // Software word index
    input  wire logic [31:0]          wdata_in,   // Software write data
    input  wire logic                 wr_in,      // Write strobe
    input  wire logic                 rd_in,      // Read strobe
    output logic [31:0]               rdata_out,  // Read data, next cycle
    input  wire logic                 nmi_in,     // NMI pulse, same clock
    input  wire logic                 fault_in,   // Hard fault pulse
    output logic                      push_out,   // One stacked word
    output logic                      enter_out,  // Handler entry pulse
    output logic [5:0]                code_out    // Entered exception code
);
    import iwd_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,   // Waiting for an exception
        ST_STACK = 2'b10    // Saving context
    } iwd_st_e;

    iwd_st_e     st_r;        // State
    iwd_st_e     st_nxt;      // Next state
    logic [3:0]  cnt_r;       // Words pushed
    logic        mask_r;      // Global mask
    logic        nmi_r;       // NMI waiting
    logic        fault_r;     // Fault waiting
    logic [5:0]  code_r;      // Exception being entered or run
    logic [31:0] lrd_r;       // Local read data
    logic        lsel_r;      // Last read was local
    logic        enter_r;     // Entry pulse

    wire idle      = (st_r == ST_IDLE);
    wire take_sys  = idle && (nmi_r || fault_r);        // Not maskable
    wire take_irq  = idle && !take_sys && link.irq_valid && !mask_r;
    wire stack_end = (st_r == ST_STACK) && (cnt_r == 4'(STACK_WORDS - 1));
    wire local_a   = (addr_in == A_MASK) || (addr_in == A_STATUS) ||
                     (addr_in == A_EOI);

    // ==========================================================
    // Next state
    always_comb begin
        case (st_r)
            ST_IDLE:  st_nxt = (take_sys || take_irq) ? ST_STACK : ST_IDLE;
            ST_STACK: st_nxt = stack_end ? ST_IDLE : ST_STACK;
            default:  st_nxt = ST_IDLE;
        endcase
    end

    // Sequencer and context save counter
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r    <= ST_IDLE;
            cnt_r   <= '0;
            code_r  <= CODE_NONE;
            enter_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= (st_r == ST_STACK) ? cnt_r + 4'h1 : 4'h0;
            enter_r <= stack_end;
            if (take_sys) begin
                code_r <= nmi_r ? CODE_NMI : CODE_FAULT;
            end else if (take_irq) begin
                code_r <= CODE_IRQ0 + 6'(link.irq_id);
            end
        end
    end

    // Mask and system exception latches; new event wins
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mask_r  <= MASK_RST;
            nmi_r   <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            if (wr_in && addr_in == A_MASK) mask_r <= wdata_in[0];
            nmi_r   <= nmi_in || (nmi_r && !take_sys);
            fault_r <= fault_in || (fault_r && !(take_sys && !nmi_r));
        end
    end

    // Local read data
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lrd_r  <= '0;
            lsel_r <= 1'b0;
        end else begin
            lsel_r <= rd_in && local_a;
            case (addr_in)
                A_MASK:   lrd_r <= {31'h0, mask_r};
                A_STATUS: lrd_r <= {24'h0, idle, 1'b0, code_r};
                default:  lrd_r <= '0;
            endcase
        end
    end

    // Device traffic; software sequencing is its own duty
    // Every write is shown; the device ignores the local word indexes
    assign link.cfg_wr    = wr_in;
    assign link.cfg_rd    = rd_in && !local_a;
    assign link.cfg_addr  = addr_in;
    assign link.cfg_wdata = wdata_in;
    assign link.irq_ack   = take_irq;
    assign link.irq_done  = wr_in && (addr_in == A_EOI);
    assign link.done_id   = wdata_in[ID_W-1:0];
    assign rdata_out      = lsel_r ? lrd_r : link.cfg_rdata;
    assign push_out       = (st_r == ST_STACK);
    assign enter_out      = enter_r;
    assign code_out       = code_r;
endmodule : iwd_cpu_end
`default_nettype wire

//--- tb/iwd_link_chk.sv
// Checker: link properties between the device end and processor end
`timescale 1ns/1ps
`default_nettype none
module iwd_link_chk import iwd_pkg::*; (
    input wire logic              clk_in,    // Clock
    input wire logic              rst_b_in,  // Reset, low
    input wire logic              cfg_wr,    // Write strobe
    input wire logic              cfg_rd,    // Read strobe
    input wire logic [ADDR_W-1:0] cfg_addr,  // Word index
    input wire logic [DATA_W-1:0] cfg_wdata, // Write data
    input wire logic [DATA_W-1:0] cfg_rdata, // Read data
    input wire logic              irq_valid, // Offer
    input wire logic              irq_ack    // Taken
);
    logic [31:0] en_r;   // Shadow of source enables
    logic        mask_r; // Shadow of global mask
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================================
    // Shadows, so reads and acceptance can be judged
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_r   <= '0;
            mask_r <= 1'b0;
        end else if (cfg_wr) begin
            if (cfg_addr == A_SET_EN) en_r <= en_r | cfg_wdata;
            if (cfg_addr == A_CLR_EN) en_r <= en_r & ~cfg_wdata;
            if (cfg_addr == A_MASK) mask_r <= cfg_wdata[0];
        end
    end
    // Write, one idle cycle, then read
    sequence s_wr_rd(wa, ra);
        cfg_wr && cfg_addr == wa ##2 cfg_rd && cfg_addr == ra;
    endsequence
    property p_pend_set;
        s_wr_rd(A_SET_PEND, A_SET_PEND) |=>
            (cfg_rdata & $past(cfg_wdata, 3)) == $past(cfg_wdata, 3);
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pend lost");
    property p_pend_clr;
        s_wr_rd(A_CLR_PEND, A_SET_PEND) |=>
            (cfg_rdata & $past(cfg_wdata, 3)) == '0;
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pend kept");
    property p_prio;
        s_wr_rd(A_PRIO0, A_PRIO0) |=> cfg_rdata == $past(cfg_wdata, 3);
    endproperty
    a_prio: assert property (p_prio) else $error("prio readback");
    property p_en; cfg_rd && cfg_addr == A_SET_EN |=> cfg_rdata == en_r;
    endproperty
    a_en: assert property (p_en) else $error("enable readback");
    property p_mask; mask_r |-> !irq_ack; endproperty
    a_mask: assert property (p_mask) else $error("ack while masked");
    property p_offer; irq_ack |-> irq_valid; endproperty
    a_offer: assert property (p_offer) else $error("ack no offer");
    property p_busy; irq_ack |=> !irq_ack [*8]; endproperty
    a_busy: assert property (p_busy) else $error("ack during save");
    property p_idle; !$past(cfg_rd) |-> cfg_rdata == '0; endproperty
    a_idle: assert property (p_idle) else $error("stray rdata");
endmodule // iwd_link_chk
`default_nettype wire

//--- tb/test_interrupt_wakeup_detect_and_dispatch.sv
// Testbench: both ends joined, driven from the software port
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_wakeup_detect_and_dispatch;
    import iwd_pkg::*;
    logic        clk_in = 1'b0;   // Clock, 40 MHz
    logic        rst_b_in = 1'b0; // Reset, low
    logic [31:0] src = '0;        // Source lines, idle low
    logic        stop = 1'b0;     // STOP mode
    logic [7:0]  addr = '0;       // Word index
    logic [31:0] wdata = '0;      // Write data
    logic        wr = 1'b0;       // Write strobe
    logic        rd = 1'b0;       // Read strobe
    logic        nmi = 1'b0;      // NMI pulse
    logic [31:0] rdata, wake, rv, pr, bits; // Outputs and scratch
    logic        push, enter;     // Save and entry
    logic [5:0]  code;            // Entered code
    int errors = 0, n_tests = 0, cyc = 0, k1, k2, p1, p2, w, seen;
    iwd_link_if link ();
    iwd_dev_end u_iwd_dev_end (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .link(link.dev), .src_in(src), .stop_in(stop), .wake_out(wake));
    iwd_cpu_end u_iwd_cpu_end (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .link(link.cpu), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .nmi_in(nmi), .fault_in(1'b0),
        .push_out(push), .enter_out(enter), .code_out(code));
    iwd_link_chk u_iwd_link_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .cfg_wr(link.cfg_wr), .cfg_rd(link.cfg_rd),
        .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata),
        .cfg_rdata(link.cfg_rdata), .irq_valid(link.irq_valid),
        .irq_ack(link.irq_ack));
    always #12.5 clk_in = ~clk_in;
    // ==========================================================
    // Compare, bus cycle, handler entry, verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op(input logic w_, input logic [7:0] a, input int d);
        @(posedge clk_in);
        wr <= w_;
        rd <= !w_;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic take(input int c);
        int n = 0;
        int p = 0;
        while (enter !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            #1 n++;
            if (push === 1'b1) p++;
        end
        chk(p, 8);
        chk(code, c);
    endtask
    task automatic print_verdict;
        $display("Tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Lower level wins, tie goes to lower number
    function automatic int winner(int a, int pa, int b, int pb);
        return (pb < pa) ? b : a;
    endfunction
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            print_verdict();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        rv = $urandom(59);
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        op(1, A_WCFG0, 32'h000B_0000); // Source 4 rising, enabled
        op(1, A_WCFG3, 32'h0B00_0000); // Source 30 rising, enabled
        src <= 32'h4000_0010;
        @(posedge clk_in);
        src <= '0;
        repeat (4) @(posedge clk_in);
        #1 chk(wake, 32'h4000_0010);
        op(1, A_WCLR, 4);
        repeat (2) @(posedge clk_in);
        #1 chk(wake, 32'h4000_0000);
        op(1, A_WCLR, 30);
        op(1, A_PIN_FSEL, 32'h20);
        op(1, A_PIN_IE, 32'h20);
        op(1, A_WCFG0, 32'h0010_0000); // Pin 5 high level first
        op(1, A_WCLR, 5);
        op(1, A_WCFG0, 32'h0090_0000); // Then enable
        src <= 32'h0000_0020; // Held until seen
        repeat (4) @(posedge clk_in);
        #1 chk(wake, 32'h20);
        stop <= 1'b1;
        op(1, A_PIN_FSEL, 0);
        @(posedge clk_in);
        #1 chk(wake, 32'h0);
        stop <= 1'b0;
        src <= '0;
        repeat (4) @(posedge clk_in);
        #1 chk(wake, 32'h0);
        for (int i = 0; i < 4; i++) begin
            k1 = 9 + $urandom % 3;
            k2 = k1 + 1 + $urandom % 4;
            p1 = $urandom % 4;
            p2 = (i == 0) ? p1 : $urandom % 4; // First pass ties
            pr = (32'(p1) << (2 * k1)) | (32'(p2) << (2 * k2));
            bits = (32'h1 << k1) | (32'h1 << k2);
            op(1, A_PRIO0, pr);
            op(0, A_PRIO0, 0);
            chk(rv, pr);
            op(1, A_CLR_EN, -1);
            op(1, A_SET_EN, bits);
            op(0, A_SET_EN, 0);
            chk(rv, bits);
            op(1, A_SET_PEND, bits);
            w = winner(k1, p1, k2, p2);
            take(CODE_IRQ0 + w);
            op(1, A_EOI, w);
            take(CODE_IRQ0 + k1 + k2 - w);
            op(1, A_EOI, k1 + k2 - w);
        end
        op(1, A_CLR_EN, -1);
        op(1, A_SET_PEND, 32'h0C00);
        op(0, A_SET_PEND, 0);
        chk(rv & 32'h0C00, 32'h0C00);
        op(1, A_CLR_PEND, 32'h0400);
        op(0, A_SET_PEND, 0);
        chk(rv & 32'h0C00, 32'h0800);
        op(1, A_MASK, 1);
        op(0, A_MASK, 0);
        chk(rv, 32'h1);
        op(1, A_SET_EN, 32'h0800);
        seen = 0;
        repeat (20) begin
            @(posedge clk_in);
            #1 if (push !== 1'b0) seen++;
        end
        chk(seen, 0);
        op(1, A_MASK, 0);
        take(CODE_IRQ0 + 11);
        op(1, A_EOI, 11);
        op(1, A_MASK, 1);
        nmi <= 1'b1;
        @(posedge clk_in);
        nmi <= 1'b0;
        take(CODE_NMI);
        print_verdict();
    end
endmodule // test_interrupt_wakeup_detect_and_dispatch
`default_nettype wire
